// *** logic/adc_reg_bank.sv ***
// Purpose: Configuration and limit flag registers behind the serial command port
// Assumes: cs_n stays high for several clk cycles between frames
// Notes: Reply word and captured word are held still while they cross domains
`timescale 1ns/1ps
module adc_reg_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic primary_serial_out,
  output logic secondary_serial_out,
  input wire logic [15:0] conv_result,
  input wire logic [7:0] limit_flags_in,
  input wire logic setup_fault_in,
  output logic averaging_style,
  output logic [2:0] oversample_ratio,
  output logic [2:0] ratio_exponent,
  output logic resolution_boost,
  output logic crc_read_enable,
  output logic input_check_enable,
  output logic power_down_select,
  output logic [1:0] output_lane_select,
  output logic [7:0] reset_command,
  output logic alert_output_enable
);
  logic [15:0] word_x;
  logic [7:0] check_x;
  logic check_seen_x;
  logic word_tgl_x;
  logic [15:0] reply_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_seen_r;
  logic [11:0] gen_r;
  logic [11:0] out_cfg_r;
  logic [11:0] upper_r;
  logic fail_r;
  logic frame_end;
  logic new_word;
  logic take;
  logic cmd_wr;
  logic [2:0] cmd_addr;
  logic [11:0] cmd_data;
  logic check_needed;
  logic check_ok;
  logic write_ok;
  logic fail_evt;
  logic flag_read;

  // Valid register addresses for writing
  function automatic logic writable(input logic [2:0] a);
    writable = (a == adc_reg_pkg::ADDR_GEN) || (a == adc_reg_pkg::ADDR_OUT) ||
               (a == adc_reg_pkg::ADDR_UPPER);
  endfunction

  // Valid register addresses for reading; none of them is write-only
  function automatic logic readable(input logic [2:0] a);
    readable = (a >= adc_reg_pkg::ADDR_GEN) && (a <= adc_reg_pkg::ADDR_UPPER);
  endfunction

  // Ratio code to power of two, forced to zero above 8x in rolling averaging
  function automatic logic [2:0] ratio_exp(input logic [2:0] code, input logic rolling);
    logic [2:0] e;
    e = 3'h0;
    unique case (code)
      adc_reg_pkg::RATIO_2X: e = 3'h1;
      adc_reg_pkg::RATIO_4X: e = 3'h2;
      adc_reg_pkg::RATIO_8X: e = 3'h3;
      adc_reg_pkg::RATIO_16X: e = 3'h4;
      adc_reg_pkg::RATIO_32X: e = 3'h5;
      default: e = 3'h0;
    endcase
    if (rolling && e > adc_reg_pkg::ROLLING_MAX_EXP) begin
      e = 3'h0;
    end
    ratio_exp = e;
  endfunction

  // Check byte over the sixteen command bits
  function automatic logic [7:0] check_byte(input logic [15:0] w);
    logic [7:0] c;
    c = adc_reg_pkg::CHECK_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ adc_reg_pkg::CHECK_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    check_byte = c;
  endfunction

  // Register contents with the address echo on top
  function automatic logic [15:0] reg_word(input logic [2:0] a, input logic [11:0] gen,
                                           input logic [11:0] oc, input logic [11:0] up,
                                           input logic fl, input logic su,
                                           input logic [7:0] lim);
    logic [11:0] body;
    body = '0;
    unique case (a)
      adc_reg_pkg::ADDR_GEN: body = gen;
      adc_reg_pkg::ADDR_OUT: body = oc;
      adc_reg_pkg::ADDR_FLAG: body = {2'h0, fl, su, lim};
      adc_reg_pkg::ADDR_LOW: body = adc_reg_pkg::LOW_RESET;
      adc_reg_pkg::ADDR_UPPER: body = up;
      default: body = '0;
    endcase
    reg_word = {1'b0, a, body};
  endfunction

  // Link-side shifter on the serial clock
  spi_frame_rx u_rx (
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .reply_word(reply_r),
    .word_out(word_x),
    .check_out(check_x),
    .check_seen(check_seen_x),
    .word_tgl(word_tgl_x),
    .primary_serial_out(primary_serial_out)
  );

  // Frame select synchroniser plus edge stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  // The word itself is not synchronised: it stands still from the sixteenth
  // edge until the next frame, long after the toggle has crossed over
  // Word toggle synchroniser and seen marker
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_s1_r <= word_tgl_x;
      tgl_s2_r <= tgl_s1_r;
      if (frame_end) begin
        tgl_seen_r <= tgl_s2_r;
      end
    end
  end

  // Command decode at the close of a full frame
  assign frame_end = cs_s2_r && !cs_s3_r;
  assign new_word = tgl_s2_r != tgl_seen_r;
  assign take = frame_end && new_word;
  assign cmd_wr = word_x[adc_reg_pkg::WR_POS];
  assign cmd_addr = word_x[adc_reg_pkg::ADDR_MSB:adc_reg_pkg::ADDR_LSB];
  assign cmd_data = word_x[adc_reg_pkg::DATA_MSB:0];

  // Writes need a check byte when the check bit flips or is already on
  assign check_needed = gen_r[adc_reg_pkg::CRCW_POS] ||
                        (cmd_addr == adc_reg_pkg::ADDR_GEN &&
                         cmd_data[adc_reg_pkg::CRCW_POS] != gen_r[adc_reg_pkg::CRCW_POS]);
  assign check_ok = check_seen_x && (check_x == check_byte(word_x));
  assign write_ok = take && cmd_wr && writable(cmd_addr) && (!check_needed || check_ok);
  assign fail_evt = take && cmd_wr && writable(cmd_addr) && check_needed && !check_ok;
  assign flag_read = take && !cmd_wr && cmd_addr == adc_reg_pkg::ADDR_FLAG;

  // General configuration register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gen_r <= adc_reg_pkg::GEN_RESET;
    end else if (write_ok && cmd_addr == adc_reg_pkg::ADDR_GEN) begin
      gen_r <= cmd_data & adc_reg_pkg::GEN_MASK;
    end
  end

  // Output configuration register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_cfg_r <= adc_reg_pkg::OUT_RESET;
    end else if (write_ok && cmd_addr == adc_reg_pkg::ADDR_OUT) begin
      out_cfg_r <= cmd_data & adc_reg_pkg::OUT_MASK;
    end
  end

  // Upper limit threshold register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_r <= adc_reg_pkg::UPPER_RESET;
    end else if (write_ok && cmd_addr == adc_reg_pkg::ADDR_UPPER) begin
      upper_r <= cmd_data;
    end
  end

  // Check failure flag, a new failure beats the clear by read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fail_r <= 1'b0;
    end else if (fail_evt) begin
      fail_r <= 1'b1;
    end else if (flag_read) begin
      fail_r <= 1'b0;
    end
  end

  // Reply word for the next frame: register or conversion data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reply_r <= '0;
    end else if (frame_end) begin
      if (take && !cmd_wr && readable(cmd_addr)) begin
        reply_r <= reg_word(cmd_addr, gen_r, out_cfg_r, upper_r, fail_r,
                            setup_fault_in, limit_flags_in);
      end else begin
        reply_r <= conv_result;
      end
    end
  end

  // Mode fields toward the converter core
  assign averaging_style = gen_r[adc_reg_pkg::AVG_POS];
  assign oversample_ratio = gen_r[adc_reg_pkg::RATIO_MSB:adc_reg_pkg::RATIO_LSB];
  assign ratio_exponent = ratio_exp(oversample_ratio, averaging_style);
  assign resolution_boost = gen_r[adc_reg_pkg::RES_POS] && (ratio_exponent != 3'h0);
  assign crc_read_enable = gen_r[adc_reg_pkg::CRCR_POS];
  assign input_check_enable = gen_r[adc_reg_pkg::CRCW_POS];
  assign power_down_select = gen_r[adc_reg_pkg::POWER_DOWN_SELECT_POS];
  assign output_lane_select = out_cfg_r[adc_reg_pkg::LANE_MSB:adc_reg_pkg::LANE_LSB];
  assign reset_command = out_cfg_r[adc_reg_pkg::RST_MSB:0];

  // Second lane becomes the limit indicator only in one-wire mode
  assign alert_output_enable = gen_r[adc_reg_pkg::ALERT_EN_POS] &&
                               (output_lane_select == adc_reg_pkg::LANE_ONE_WIRE);
  assign secondary_serial_out = alert_output_enable && (|limit_flags_in);

  // Checks on the clk side
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  gen_write_a: assert property (
    write_ok && cmd_addr == adc_reg_pkg::ADDR_GEN |=>
      gen_r == ($past(cmd_data) & adc_reg_pkg::GEN_MASK))
    else $error("general config write lost");
  read_reply_a: assert property (
    take && !cmd_wr && cmd_addr == adc_reg_pkg::ADDR_UPPER |=>
      reply_r == {1'b0, adc_reg_pkg::ADDR_UPPER, $past(upper_r)})
    else $error("upper threshold read wrong");
  nop_read_a: assert property (
    take && !cmd_wr && (cmd_addr == adc_reg_pkg::ADDR_NOP0 ||
      cmd_addr == adc_reg_pkg::ADDR_NOP6 || cmd_addr == adc_reg_pkg::ADDR_NOP7) |=>
      reply_r == $past(conv_result))
    else $error("no-operation read did not give conversion data");
  ro_write_a: assert property (
    take && cmd_wr && !writable(cmd_addr) |=>
      $stable(gen_r) && $stable(out_cfg_r) && $stable(upper_r))
    else $error("write to read-only address changed state");
  flag_read_a: assert property (
    take && !cmd_wr && cmd_addr == adc_reg_pkg::ADDR_FLAG |=>
      reply_r[7:0] == $past(limit_flags_in))
    else $error("limit flags not returned");
  check_guard_a: assert property (
    fail_evt |=> $stable(gen_r) && $stable(upper_r) && fail_r)
    else $error("unchecked write accepted");
  boost_gate_a: assert property (
    ratio_exponent == 3'h0 |-> !resolution_boost)
    else $error("boost active without oversampling");
  alert_gate_a: assert property (
    output_lane_select != adc_reg_pkg::LANE_ONE_WIRE |-> !alert_output_enable)
    else $error("alert active outside one-wire mode");
  rolling_cap_a: assert property (
    averaging_style |-> ratio_exponent <= adc_reg_pkg::ROLLING_MAX_EXP)
    else $error("rolling ratio above 8x");
  ratio_code_a: assert property (
    !averaging_style && oversample_ratio == adc_reg_pkg::RATIO_4X |-> ratio_exponent == 3'h2)
    else $error("ratio code 2 not 4x");
  ratio_off_a: assert property (
    oversample_ratio > adc_reg_pkg::RATIO_32X |-> ratio_exponent == 3'h0)
    else $error("codes 6 and 7 must disable");

  // Further register writes land one cycle after the decode
  out_write_a: assert property (
    write_ok && cmd_addr == adc_reg_pkg::ADDR_OUT |=>
      out_cfg_r == ($past(cmd_data) & adc_reg_pkg::OUT_MASK))
    else $error("output config write lost");
  upper_write_a: assert property (
    write_ok && cmd_addr == adc_reg_pkg::ADDR_UPPER |=> upper_r == $past(cmd_data))
    else $error("upper threshold write lost");
  check_pass_a: assert property (
    take && cmd_wr && cmd_addr == adc_reg_pkg::ADDR_GEN && check_ok |=>
      gen_r == ($past(cmd_data) & adc_reg_pkg::GEN_MASK))
    else $error("checked write refused");

  // Configuration and threshold registers hold when no accepted write arrives; a flag read clears the fail flag
  quiet_hold_a: assert property (
    !write_ok |=> $stable(gen_r) && $stable(out_cfg_r) && $stable(upper_r))
    else $error("register changed without a write");
  fail_clear_a: assert property (
    flag_read |=> !fail_r)
    else $error("fail flag not cleared by read");

  // Reply word sources
  gen_read_a: assert property (
    take && !cmd_wr && cmd_addr == adc_reg_pkg::ADDR_GEN |=>
      reply_r == {1'b0, adc_reg_pkg::ADDR_GEN, $past(gen_r)})
    else $error("general config read wrong");
  low_read_a: assert property (
    take && !cmd_wr && cmd_addr == adc_reg_pkg::ADDR_LOW |=>
      reply_r == {1'b0, adc_reg_pkg::ADDR_LOW, adc_reg_pkg::LOW_RESET})
    else $error("lower threshold read wrong");
  idle_reply_a: assert property (
    frame_end && !take |=> reply_r == $past(conv_result))
    else $error("dropped frame did not give conversion data");
  fault_read_a: assert property (
    take && !cmd_wr && cmd_addr == adc_reg_pkg::ADDR_FLAG |=>
      reply_r[adc_reg_pkg::FAIL_POS] == $past(fail_r) &&
      reply_r[adc_reg_pkg::SETUP_POS] == $past(setup_fault_in))
    else $error("limit register status bits wrong");

  // Main traffic seen at least once
  write_seen_c: cover property (write_ok && cmd_addr == adc_reg_pkg::ADDR_GEN);
  read_seen_c: cover property (take && !cmd_wr && readable(cmd_addr));
  nop_seen_c: cover property (take && !cmd_wr && !readable(cmd_addr));
  fail_seen_c: cover property (fail_evt);
  check_pass_c: cover property (write_ok && check_needed);
endmodule

// *** logic/adc_reg_pkg.sv ***
// Purpose: Shared constants for the serial register access block
// Assumes: 16-bit command frames, optional 8-bit check byte after the word
// Notes: All field positions, addresses and reset values live here
package adc_reg_pkg;
  // Frame geometry
  localparam int FRAME_BITS = 16;
  localparam int CHECK_BITS = 8;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_WORD_BIT = 5'h0f;
  localparam logic [4:0] LAST_CHECK_BIT = 5'h17;
  localparam logic [4:0] CNT_MAX = 5'h1f;

  // Command word fields
  localparam int WR_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 12;
  localparam int DATA_MSB = 11;
  localparam int DATA_W = 12;

  // Register addresses
  localparam logic [2:0] ADDR_NOP0 = 3'h0;
  localparam logic [2:0] ADDR_GEN = 3'h1;
  localparam logic [2:0] ADDR_OUT = 3'h2;
  localparam logic [2:0] ADDR_FLAG = 3'h3;
  localparam logic [2:0] ADDR_LOW = 3'h4;
  localparam logic [2:0] ADDR_UPPER = 3'h5;
  localparam logic [2:0] ADDR_NOP6 = 3'h6;
  localparam logic [2:0] ADDR_NOP7 = 3'h7;

  // Reset values of register contents
  localparam logic [11:0] GEN_RESET = 12'h000;
  localparam logic [11:0] OUT_RESET = 12'h000;
  localparam logic [11:0] LOW_RESET = 12'h800;
  localparam logic [11:0] UPPER_RESET = 12'h7ff;

  // Writable bits of each configuration register
  localparam logic [11:0] GEN_MASK = 12'h3fd;
  localparam logic [11:0] OUT_MASK = 12'h3ff;

  // General configuration fields
  localparam int AVG_POS = 9;
  localparam int RATIO_MSB = 8;
  localparam int RATIO_LSB = 6;
  localparam int CRCW_POS = 5;
  localparam int CRCR_POS = 4;
  localparam int ALERT_EN_POS = 3;
  localparam int RES_POS = 2;
  localparam int POWER_DOWN_SELECT_POS = 0;

  // Output configuration fields
  localparam int LANE_MSB = 9;
  localparam int LANE_LSB = 8;
  localparam int RST_MSB = 7;
  localparam logic [1:0] LANE_ONE_WIRE = 2'h1;

  // Limit flag register fields
  localparam int FAIL_POS = 9;
  localparam int SETUP_POS = 8;

  // Ratio codes and their power-of-two exponents
  localparam logic [2:0] RATIO_OFF = 3'h0;
  localparam logic [2:0] RATIO_2X = 3'h1;
  localparam logic [2:0] RATIO_4X = 3'h2;
  localparam logic [2:0] RATIO_8X = 3'h3;
  localparam logic [2:0] RATIO_16X = 3'h4;
  localparam logic [2:0] RATIO_32X = 3'h5;
  localparam logic [2:0] ROLLING_MAX_EXP = 3'h3;

  // Check byte polynomial x^8+x^2+x+1 and start value
  localparam logic [7:0] CHECK_POLY = 8'h07;
  localparam logic [7:0] CHECK_INIT = 8'h00;
endpackage

// *** logic/spi_frame_rx.sv ***
// Purpose: Link-side shifter running on the serial clock
// Assumes: Host drives sdi before each rising sclk edge; sclk idles outside frames
// Notes: Captured word and check byte hold still until the next frame fills them
`timescale 1ns/1ps
module spi_frame_rx (
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [15:0] reply_word,
  output logic [15:0] word_out,
  output logic [7:0] check_out,
  output logic check_seen,
  output logic word_tgl,
  output logic primary_serial_out
);
  logic frame_idle;
  logic [4:0] cnt_r;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic out_r;
  logic out_live_r;

  // Counter and output phase restart whenever the frame closes
  assign frame_idle = cs_n || !resetn;
  assign shift_nxt = {shift_r[14:0], sdi};

  // Bit counter, saturating past the check byte
  always_ff @(posedge sclk or posedge frame_idle) begin
    if (frame_idle) begin
      cnt_r <= '0;
    end else if (cnt_r != adc_reg_pkg::CNT_MAX) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Input shifter, msb first
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Word capture on the sixteenth edge, check byte on the twenty-fourth
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      word_out <= '0;
      check_out <= adc_reg_pkg::CHECK_INIT;
      check_seen <= 1'b0;
      word_tgl <= 1'b0;
    end else if (!cs_n && cnt_r == adc_reg_pkg::LAST_WORD_BIT) begin
      word_out <= shift_nxt;
      word_tgl <= !word_tgl;
      check_seen <= 1'b0;
    end else if (!cs_n && cnt_r == adc_reg_pkg::LAST_CHECK_BIT) begin
      check_out <= shift_nxt[7:0];
      check_seen <= 1'b1;
    end
  end

  // Reply shifter changes on falling edges
  always_ff @(negedge sclk or posedge frame_idle) begin
    if (frame_idle) begin
      out_r <= 1'b0;
      out_live_r <= 1'b0;
    end else begin
      out_live_r <= 1'b1;
      if (cnt_r < 5'(adc_reg_pkg::FRAME_BITS)) begin
        out_r <= reply_word[4'(adc_reg_pkg::LAST_WORD_BIT - cnt_r)];
      end else begin
        out_r <= 1'b0;
      end
    end
  end

  // First bit shows as soon as the frame opens
  assign primary_serial_out = cs_n ? 1'b0 : (out_live_r ? out_r : reply_word[15]);

  // Word capture happens only on the sixteenth edge
  word_count_a: assert property (@(posedge sclk) disable iff (frame_idle)
    cnt_r != adc_reg_pkg::LAST_WORD_BIT |=> $stable(word_tgl))
    else $error("word taken on a wrong edge");
  word_edge_a: assert property (@(posedge sclk) disable iff (frame_idle)
    cnt_r == adc_reg_pkg::LAST_WORD_BIT |=> word_tgl != $past(word_tgl))
    else $error("word not taken on edge sixteen");
endmodule

// *** testbench/spi_host_model.sv ***
// Purpose: Behavioural SPI host that sends command frames to the register block
// Assumes: Device samples sdi on rising sclk and shifts its reply on falling sclk
// Notes: sclk rests low between frames; sdi flips when released so it never looks held
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic miso
);
  // Idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One frame of nbits clocks, msb first; reply bits taken at rising edges
  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    cs_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      sdi = tx[23-i];
      #16;
      sclk = 1'b1;
      if (i < 16) begin
        rx[15-i] = miso;
      end
      #16;
      sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    sdi = ~sdi;
    // Gap covers the 48 ns minimum and the reply hand-over
    #100;
  endtask
endmodule

// *** testbench/tb_adc_reg_bank.sv ***
// Purpose: Self-checking bench for the serial register access block
// Assumes: Host model drives the link; clk-domain inputs change 1 ns after clk rises
// Notes: Each scenario task drives frames and judges the replies before returning
`timescale 1ns/1ps
module tb_adc_reg_bank;
  logic clk, resetn, sclk, cs_n, sdi, pso, sso, setup_fault_in;
  logic [15:0] conv_result;
  logic [7:0] limit_flags_in;
  logic avg, boost, crc_rd, chk_en, pd, alert_en;
  logic [2:0] ratio, expo;
  logic [1:0] lane;
  logic [7:0] rst_cmd;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;

  adc_reg_bank dut (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .primary_serial_out(pso), .secondary_serial_out(sso), .conv_result(conv_result),
    .limit_flags_in(limit_flags_in), .setup_fault_in(setup_fault_in),
    .averaging_style(avg), .oversample_ratio(ratio), .ratio_exponent(expo),
    .resolution_boost(boost), .crc_read_enable(crc_rd), .input_check_enable(chk_en),
    .power_down_select(pd), .output_lane_select(lane), .reset_command(rst_cmd),
    .alert_output_enable(alert_en)
  );

  spi_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .miso(pso));

  // System clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Clock-domain inputs change just after a rising edge
  task automatic drive(input logic [15:0] cv, input logic [7:0] fl, input logic su);
    @(posedge clk);
    #1;
    conv_result = cv;
    limit_flags_in = fl;
    setup_fault_in = su;
  endtask

  task automatic send(input logic [15:0] w);
    logic [15:0] rx;
    host.xfer({w, 8'h00}, 16, rx);
  endtask

  // Read request, then a no-operation frame that carries the reply
  task automatic rd(input logic [2:0] a, output logic [15:0] rx);
    host.xfer({1'b0, a, 12'h000, 8'h00}, 16, rx);
    host.xfer(24'h000000, 16, rx);
  endtask

  task automatic t_reset;
    logic [11:0] val [1:5];
    logic [15:0] rx;
    int a;
    val = '{12'h000, 12'h000, 12'h000, 12'h800, 12'h7ff};
    chk({2'b00, avg, ratio, expo, boost, crc_rd, chk_en, pd, lane, 1'b0}, 16'h0000, "cfg out");
    for (a = 1; a <= 5; a++) begin
      rd(a[2:0], rx);
      chk(rx, {1'b0, a[2:0], val[a]}, "reset read");
    end
  endtask

  task automatic t_ratio;
    logic [15:0] rx;
    logic [2:0] c, e;
    int s, k;
    for (s = 0; s < 2; s++) begin
      for (k = 0; k < 8; k++) begin
        c = k[2:0];
        e = (k >= 1 && k <= 5 && !(s == 1 && k > 3)) ? c : 3'h0;
        send({4'h9, 2'b00, s[0], c, 3'b000, 1'b1, 2'b00});
        chk({8'h00, avg, ratio, expo, boost}, {8'h00, s[0], c, e, e != 3'h0}, "ratio");
      end
    end
    rd(3'h1, rx);
    chk(rx, 16'h13c4, "general readback");
  endtask

  task automatic t_refuse;
    logic [15:0] rx;
    send(16'h8fff);
    send(16'hbfff);
    send(16'hcfff);
    send(16'hefff);
    send(16'hffff);
    rd(3'h4, rx);
    chk(rx, 16'h4800, "lower threshold");
    rd(3'h3, rx);
    chk(rx, 16'h3000, "flag reg");
    rd(3'h1, rx);
    chk(rx, 16'h13c4, "general kept");
    send(16'hd123);
    rd(3'h5, rx);
    chk(rx, 16'h5123, "upper write");
  endtask

  task automatic t_nop;
    logic [15:0] rx;
    logic [2:0] a [3];
    int i;
    a = '{3'h0, 3'h6, 3'h7};
    drive(16'ha5c3, 8'h00, 1'b0);
    for (i = 0; i < 3; i++) begin
      host.xfer({1'b0, a[i], 12'h000, 8'h00}, 16, rx);
      host.xfer(24'h500000, 16, rx);
      chk(rx, 16'ha5c3, "nop read");
    end
    host.xfer(24'h500000, 10, rx);
    host.xfer(24'h000000, 16, rx);
    chk(rx, 16'ha5c3, "short frame");
  endtask

  task automatic t_alert;
    logic [15:0] rx;
    drive(16'h0000, 8'h81, 1'b1);
    rd(3'h3, rx);
    chk(rx, 16'h3181, "flag bits");
    send(16'ha15a);
    send(16'h9008);
    chk({4'h0, alert_en, sso, lane, rst_cmd}, 16'h0d5a, "alert on");
    send(16'ha000);
    chk({14'h0000, alert_en, sso}, 16'h0000, "alert off");
  endtask

  task automatic t_check;
    logic [15:0] rx;
    send(16'h9028);
    chk({15'h0000, chk_en}, 16'h0000, "check bit");
    rd(3'h3, rx);
    chk(rx, 16'h3381, "fail flag");
    rd(3'h3, rx);
    chk(rx, 16'h3181, "fail cleared");
    rd(3'h1, rx);
    chk(rx, 16'h1008, "general kept");
    host.xfer({16'h9031, 8'h76}, 24, rx);
    chk({13'h0, crc_rd, chk_en, pd}, 16'h0007, "checked write");
    send(16'hd000);
    rd(3'h5, rx);
    chk(rx, 16'h5123, "unchecked write");
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    conv_result = 16'h0000;
    limit_flags_in = 8'h00;
    setup_fault_in = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_ratio();
    t_refuse();
    t_nop();
    t_alert();
    t_check();
    summarize();
  end
endmodule
